// [cfbe_decode.sv]
// Package of shared constants and the opcode decoder for the conditional branch unit.
`timescale 1ns/100ps
`default_nettype none

package cfbe_pkg;
  // Upper byte of each conditional branch word; the offset sits in the low byte.
  localparam logic [7:0] CFBE_OPC_NOT_ZERO = 8'he1;
  localparam logic [7:0] CFBE_OPC_NO_OVF   = 8'he5;
  localparam logic [7:0] CFBE_OPC_NOT_NEG  = 8'he7;
  // Offset literal width and the range of n that it spans.
  localparam int         CFBE_OFS_W        = 8;
  localparam int         CFBE_OFS_MIN      = -128;
  localparam int         CFBE_OFS_MAX      = 127;
  // Program counter width, in byte addresses.
  localparam int         CFBE_PC_W_DEF     = 21;
  // Bytes per program word, added to the branch address on fall-through.
  localparam int         CFBE_WORD_BYTES   = 2;
  // Phase codes of the four-phase instruction cycle.
  localparam logic [1:0] CFBE_PH_Q1        = 2'h0;
  localparam logic [1:0] CFBE_PH_Q2        = 2'h1;
  localparam logic [1:0] CFBE_PH_Q3        = 2'h2;
  localparam logic [1:0] CFBE_PH_Q4        = 2'h3;

  typedef enum logic {
    CFBE_RUN   = 1'b0,
    CFBE_FLUSH = 1'b1
  } cfbe_state_t;

  typedef enum logic [1:0] {
    CFBE_BR_NONE = 2'b00,
    CFBE_BR_NZ   = 2'b01,
    CFBE_BR_NOV  = 2'b10,
    CFBE_BR_NN   = 2'b11
  } cfbe_br_t;

  function automatic cfbe_br_t cfbe_classify(input logic [7:0] opc);
    cfbe_br_t k;
    k = CFBE_BR_NONE;
    if (opc == CFBE_OPC_NOT_ZERO) begin
      k = CFBE_BR_NZ;
    end else if (opc == CFBE_OPC_NO_OVF) begin
      k = CFBE_BR_NOV;
    end else if (opc == CFBE_OPC_NOT_NEG) begin
      k = CFBE_BR_NN;
    end
    return k;
  endfunction : cfbe_classify
endpackage : cfbe_pkg

module cfbe_decode
  import cfbe_pkg::*;
(
  // Instruction upper byte.
  input  wire logic [7:0] i_opc,
  // Status flags.
  input  wire logic       i_flag_n,
  input  wire logic       i_flag_ov,
  input  wire logic       i_flag_z,
  // Decode result.
  output cfbe_pkg::cfbe_br_t o_kind,
  output logic            o_take
);
  always_comb begin
    o_kind = cfbe_classify(i_opc);
    case (o_kind)
      CFBE_BR_NZ:  o_take = ~i_flag_z;
      CFBE_BR_NOV: o_take = ~i_flag_ov;
      CFBE_BR_NN:  o_take = ~i_flag_n;
      default:     o_take = 1'b0;
    endcase
  end
endmodule : cfbe_decode

`default_nettype wire

// [cfbe_branch_exec.sv]
// Execution of the single-word conditional relative branches of the core.
// Functional notes
// - No-overflow branch is taken only while the overflow flag is zero.
// - Taken target is incremented PC plus twice the signed offset.
// - Offset is 8-bit two's complement, -128 to 127, doubled before adding.
// - One word; one instruction cycle if not taken, two if taken.
// - Q1 decode, Q2 read offset, Q3 process, Q4 write PC; second cycle idle.
// - Not-zero branch jumps when zero flag is 0, else falls to address plus 2.
// - Not taken leaves PC at the next word, two bytes past the branch.
// - Not-negative branch, upper byte e7, taken only while negative flag is zero.
// - Not-negative branch uses the same offset arithmetic as the others.
`timescale 1ns/100ps
`default_nettype none

module cfbe_branch_exec #(
  parameter int PC_W = cfbe_pkg::CFBE_PC_W_DEF
) (
  // Clock and reset.
  input  wire logic            I_CLK_SYS,
  input  wire logic            I_SYS_RST,
  // Fetched instruction and the already advanced program counter.
  input  wire logic [15:0]     I_INSTR_WORD,
  input  wire logic            I_INSTR_VALID,
  input  wire logic [PC_W-1:0] I_PC_INCR,
  // Status flags from the ALU.
  input  wire logic            I_FLAG_N,
  input  wire logic            I_FLAG_OV,
  input  wire logic            I_FLAG_Z,
  // Program counter update.
  output logic [PC_W-1:0]      O_PC_NEXT,
  output logic                 O_PC_WRITE,
  // Cycle timing.
  output logic [1:0]           O_QPHASE,
  output logic                 O_NOP_CYCLE,
  output logic                 O_BRANCH_SEEN
);
  import cfbe_pkg::*;

  if (PC_W < 10 || PC_W > 32) begin : g_bad_pc_w
    $error("PC_W must lie between 10 and 32");
  end

  // The offset is widened by sign, then shifted once, so the word grid is kept.
  function automatic logic [PC_W-1:0] dbl_ofs(input logic [CFBE_OFS_W-1:0] n);
    logic [PC_W:0] t;
    t = {{(PC_W-CFBE_OFS_W){n[CFBE_OFS_W-1]}}, n, 1'b0};
    return t[PC_W-1:0];
  endfunction : dbl_ofs

  cfbe_br_t            dec_kind;
  logic                dec_take;
  logic [1:0]          ph_q,       ph_d;
  cfbe_state_t         st_q,       st_d;
  cfbe_br_t            kind_q,     kind_d;
  logic                take_q,     take_d;
  logic [7:0]          lit_q,      lit_d;
  logic [7:0]          off_q,      off_d;
  logic [PC_W-1:0]     pc_next_q,  pc_next_d;
  logic                pc_wr_q,    pc_wr_d;
  logic                nop_q,      nop_d;
  logic                seen_q,     seen_d;

  cfbe_decode u_decode (
    .i_opc     (I_INSTR_WORD[15:8]),
    .i_flag_n  (I_FLAG_N),
    .i_flag_ov (I_FLAG_OV),
    .i_flag_z  (I_FLAG_Z),
    .o_kind    (dec_kind),
    .o_take    (dec_take)
  );

  always_comb begin
    ph_d      = ph_q + 2'h1;
    st_d      = st_q;
    kind_d    = kind_q;
    take_d    = take_q;
    lit_d     = lit_q;
    off_d     = off_q;
    pc_next_d = pc_next_q;
    pc_wr_d   = 1'b0;
    nop_d     = nop_q;
    seen_d    = seen_q;
    case (ph_q)
      CFBE_PH_Q1: begin
        // Flags are sampled at decode; the previous instruction wrote them in its Q4.
        if (st_q == CFBE_RUN && I_INSTR_VALID) begin
          kind_d = dec_kind;
          take_d = dec_take;
          lit_d  = I_INSTR_WORD[7:0];
        end else begin
          // The idle second cycle of a taken branch ignores the fetched word.
          kind_d = CFBE_BR_NONE;
          take_d = 1'b0;
        end
        seen_d = (st_q == CFBE_RUN) && I_INSTR_VALID && (dec_kind != CFBE_BR_NONE);
      end
      CFBE_PH_Q2: begin
        off_d = lit_q;
      end
      CFBE_PH_Q3: begin
        if (kind_q != CFBE_BR_NONE && take_q) begin
          pc_next_d = I_PC_INCR + dbl_ofs(off_q);
          pc_wr_d   = 1'b1;
        end else begin
          pc_next_d = I_PC_INCR;
        end
      end
      default: begin
        // Q4 ends the instruction cycle; a taken branch buys one idle cycle.
        seen_d = 1'b0;
        nop_d  = pc_wr_q;
        st_d   = pc_wr_q ? CFBE_FLUSH : CFBE_RUN;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ph_q      <= CFBE_PH_Q1;
      st_q      <= CFBE_RUN;
      kind_q    <= CFBE_BR_NONE;
      take_q    <= 1'b0;
      lit_q     <= 8'h00;
      off_q     <= 8'h00;
      pc_next_q <= '0;
      pc_wr_q   <= 1'b0;
      nop_q     <= 1'b0;
      seen_q    <= 1'b0;
    end else begin
      ph_q      <= ph_d;
      st_q      <= st_d;
      kind_q    <= kind_d;
      take_q    <= take_d;
      lit_q     <= lit_d;
      off_q     <= off_d;
      pc_next_q <= pc_next_d;
      pc_wr_q   <= pc_wr_d;
      nop_q     <= nop_d;
      seen_q    <= seen_d;
    end
  end

  // No flag output exists: none of these branches can touch the status bits.
  assign O_PC_NEXT     = pc_next_q;
  assign O_PC_WRITE    = pc_wr_q;
  assign O_QPHASE      = ph_q;
  assign O_NOP_CYCLE   = nop_q;
  assign O_BRANCH_SEEN = seen_q;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  sequence s_decode(logic [7:0] opc, logic flag);
    ph_q == CFBE_PH_Q1 && st_q == CFBE_RUN && I_INSTR_VALID &&
      I_INSTR_WORD[15:8] == opc && flag == 1'b0;
  endsequence

  sequence s_decode_set(logic [7:0] opc, logic flag);
    ph_q == CFBE_PH_Q1 && st_q == CFBE_RUN && I_INSTR_VALID &&
      I_INSTR_WORD[15:8] == opc && flag == 1'b1;
  endsequence

  sequence s_idle_cycle;
    O_NOP_CYCLE [*4] ##1 !O_NOP_CYCLE;
  endsequence

  a_nov_taken: assert property (
    s_decode(CFBE_OPC_NO_OVF, I_FLAG_OV) |-> ##3 O_PC_WRITE)
    else $error("no-overflow branch not taken with overflow clear");

  a_nov_fall: assert property (
    s_decode_set(CFBE_OPC_NO_OVF, I_FLAG_OV) |-> ##3 !O_PC_WRITE ##1 !O_NOP_CYCLE)
    else $error("no-overflow branch taken with overflow set");

  a_nz_taken: assert property (
    s_decode(CFBE_OPC_NOT_ZERO, I_FLAG_Z) |-> ##3 O_PC_WRITE)
    else $error("not-zero branch not taken with zero clear");

  a_nz_fall: assert property (
    s_decode_set(CFBE_OPC_NOT_ZERO, I_FLAG_Z) |->
      ##3 (!O_PC_WRITE && O_PC_NEXT == $past(I_PC_INCR)))
    else $error("not-zero branch did not fall through with zero set");

  a_nn_taken: assert property (
    s_decode(CFBE_OPC_NOT_NEG, I_FLAG_N) |-> ##3 O_PC_WRITE)
    else $error("not-negative branch not taken with negative clear");

  a_nn_fall: assert property (
    s_decode_set(CFBE_OPC_NOT_NEG, I_FLAG_N) |-> ##3 !O_PC_WRITE)
    else $error("not-negative branch taken with negative set");

  a_target_math: assert property (
    O_PC_WRITE |->
      O_PC_NEXT == $past(I_PC_INCR) + dbl_ofs($past(I_INSTR_WORD[7:0], 3)))
    else $error("branch target is not pc plus two plus twice the offset");

  a_write_in_q4: assert property (
    O_PC_WRITE |-> (O_QPHASE == CFBE_PH_Q4 && !O_NOP_CYCLE && $past(O_BRANCH_SEEN)))
    else $error("pc written outside Q4 of a branch cycle");

  a_taken_two_cyc: assert property (
    O_PC_WRITE |=> s_idle_cycle)
    else $error("taken branch did not spend exactly one idle cycle");

  a_idle_no_write: assert property (
    O_NOP_CYCLE |-> !O_PC_WRITE && !O_BRANCH_SEEN)
    else $error("activity during the idle cycle of a taken branch");

  a_fall_one_cyc: assert property (
    (O_QPHASE == CFBE_PH_Q4 && O_BRANCH_SEEN && !O_PC_WRITE) |=> !O_NOP_CYCLE [*4])
    else $error("untaken branch stretched beyond one cycle");

  a_phase_walk: assert property (
    O_QPHASE == CFBE_PH_Q4 |=> O_QPHASE == CFBE_PH_Q1)
    else $error("instruction phase did not wrap after Q4");

endmodule : cfbe_branch_exec

`default_nettype wire

// [cfbe_fetch_model.sv]
// Fetch model that presents one instruction word for a single Q1 edge.
`timescale 1ns/100ps
`default_nettype none

module cfbe_fetch_model (
  // Clock and load request.
  input  wire logic        i_clk,
  input  wire logic        i_load,
  input  wire logic [15:0] i_word,
  // Fetched word towards the core.
  output logic      [15:0] o_word,
  output logic             o_valid
);
  // Once released the bus shows the inverse word, so a stale copy is never mistaken for data.
  always_ff @(posedge i_clk) begin
    o_valid <= i_load;
    o_word  <= i_load ? i_word : ~i_word;
  end
endmodule : cfbe_fetch_model

`default_nettype wire

// [tb.sv]
// Self-checking bench for the conditional branch execution block.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import cfbe_pkg::*;
  localparam int PC_W = 21;
  logic            clk     = 1'b0;
  logic            rst     = 1'b1;
  logic            load    = 1'b0;
  logic [15:0]     word_in = 16'h0000;
  logic [PC_W-1:0] pc      = 21'h00000;
  logic            fn      = 1'b0;
  logic            fov     = 1'b0;
  logic            fz      = 1'b0;
  logic [15:0]     word;
  logic            valid;
  logic [PC_W-1:0] pc_next;
  logic            pc_wr;
  logic [1:0]      qph;
  logic            nop;
  logic            seen;
  int              n_fail  = 0;
  int              checks  = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  cfbe_fetch_model i_cfbe_fetch_model (.i_clk(clk), .i_load(load), .i_word(word_in),
    .o_word(word), .o_valid(valid));

  cfbe_branch_exec #(.PC_W(PC_W)) i_cfbe_branch_exec (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .I_INSTR_WORD(word), .I_INSTR_VALID(valid), .I_PC_INCR(pc), .I_FLAG_N(fn),
    .I_FLAG_OV(fov), .I_FLAG_Z(fz), .O_PC_NEXT(pc_next), .O_PC_WRITE(pc_wr),
    .O_QPHASE(qph), .O_NOP_CYCLE(nop), .O_BRANCH_SEEN(seen));

  task automatic conclude;
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_vec

  // Flags are given as {negative, overflow, zero} and are inverted after Q1 on purpose.
  task automatic exec(input logic [15:0] w, input logic [2:0] nvz, input logic [PC_W-1:0] p,
                      input logic take);
    logic [PC_W-1:0] exp;
    int              i;
    exp = take ? p + {{(PC_W-9){w[7]}}, w[7:0], 1'b0} : p;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (!(qph === CFBE_PH_Q3 && seen === 1'b0) && i < 16);
    if (i >= 16) begin
      n_fail++;
      conclude();
    end
    // The fetch model registers the request, so load rises one edge ahead of the Q1 edge.
    @(posedge clk);
    load    <= 1'b1;
    word_in <= w;
    @(posedge clk);
    load          <= 1'b0;
    {fn, fov, fz} <= nvz;
    pc            <= p;
    @(posedge clk);
    {fn, fov, fz} <= ~nvz;
    @(negedge clk);
    chk_vec("phase", 32'(CFBE_PH_Q2), 32'(qph));
    chk_bit("seen", w[15:8] inside {CFBE_OPC_NOT_ZERO, CFBE_OPC_NO_OVF, CFBE_OPC_NOT_NEG},
            seen);
    repeat (2) @(posedge clk);
    pc <= ~p;
    @(negedge clk);
    chk_bit("pc_write", take, pc_wr);
    chk_vec("pc_next", 32'(exp), 32'(pc_next));
    @(negedge clk);
    chk_bit("nop_cycle", take, nop);
  endtask : exec

  task automatic t_no_ovf;
    exec(16'he505, 3'b101, 21'h00100, 1'b1);
    exec(16'he505, 3'b010, 21'h00100, 1'b0);
  endtask : t_no_ovf

  task automatic t_not_zero;
    exec(16'he180, 3'b110, 21'h01000, 1'b1);
    exec(16'he180, 3'b001, 21'h01000, 1'b0);
  endtask : t_not_zero

  task automatic t_not_neg;
    exec(16'he77f, 3'b011, 21'h00200, 1'b1);
    exec(16'he77f, 3'b100, 21'h00200, 1'b0);
  endtask : t_not_neg

  task automatic t_foreign;
    exec(16'he610, 3'b000, 21'h00300, 1'b0);
    exec(16'he210, 3'b000, 21'h00300, 1'b0);
  endtask : t_foreign

  // Offsets at both ends of the range, with the sum wrapping in the counter width.
  task automatic t_wrap;
    exec(16'he180, 3'b000, 21'h00002, 1'b1);
    exec(16'he57f, 3'b000, 21'h1ffffe, 1'b1);
  endtask : t_wrap

  initial begin
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk_vec("phase", 32'(CFBE_PH_Q1), 32'(qph));
    chk_bit("pc_write", 1'b0, pc_wr);
    @(posedge clk);
    rst <= 1'b0;
    t_no_ovf();
    t_not_zero();
    t_not_neg();
    t_foreign();
    t_wrap();
    conclude();
  end
endmodule : tb

`default_nettype wire
